//--- hdl/npss_node_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module npss_node_sequencer #(
    parameter int unsigned STABILIZE_CYCLES  = npss_pkg::STABILIZE_CYC,
    parameter int unsigned SUPPLY_SET_CYCLES = npss_pkg::SUPPLY_SET_CYC,
    parameter int unsigned BOOT_CYCLES       = npss_pkg::BOOT_CYC,
    parameter int unsigned LINGER_CYCLES     = npss_pkg::LINGER_CYC
) (
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       power_enable_in,
    input  wire logic       node_resetn_in,
    input  wire logic       host_request_in,
    input  wire logic       sclk_in,
    input  wire logic       cs_n_in,
    input  wire logic       mosi_in,
    input  wire logic       self_wake_in,
    input  wire logic       attention_in,
    input  wire logic       radio_on_in,
    input  wire logic [7:0] tx_data_in,
    output logic            supply_demand_out,
    output logic            radio_active_out,
    output logic            node_ready_out,
    output logic            node_request_out,
    output logic            miso_out,
    output logic            miso_oe_out,
    output logic [7:0]      rx_data_out,
    output logic            rx_valid_out
);

    localparam int unsigned CW = npss_pkg::CNT_W;
    localparam int unsigned SN = npss_pkg::SYNC_N;

    // pin synchroniser: stage one feeds stage two only
    logic [SN-1:0] sync1_r;
    logic [SN-1:0] sync2_r;
    logic [SN-1:0] sync3_r;
    logic [SN-1:0] pin_r;
    logic [SN-1:0] pin_nxt;

    always_comb begin
        // a pin changes once stages two and three agree
        for (int i = 0; i < SN; i++) begin
            pin_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : pin_r[i];
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            sync1_r <= npss_pkg::PIN_RESET;
            sync2_r <= npss_pkg::PIN_RESET;
            sync3_r <= npss_pkg::PIN_RESET;
            pin_r   <= npss_pkg::PIN_RESET;
        end else begin
            sync1_r <= {mosi_in, cs_n_in, sclk_in,
                        host_request_in, node_resetn_in, power_enable_in};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_r   <= pin_nxt;
        end
    end

    logic pwr;
    logic node_rstn;
    logic hreq;
    logic sclk;
    logic cs_n;
    logic mosi;

    assign pwr       = pin_r[npss_pkg::PIN_PWR];
    assign node_rstn = pin_r[npss_pkg::PIN_RSTN];
    assign hreq      = pin_r[npss_pkg::PIN_HREQ];
    assign sclk      = pin_r[npss_pkg::PIN_SCLK];
    assign cs_n      = pin_r[npss_pkg::PIN_CSN];
    assign mosi      = pin_r[npss_pkg::PIN_MOSI];

    // power and wake sequencing
    npss_pkg::npss_state_t state_r;
    npss_pkg::npss_state_t state_nxt;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          demand_r;
    logic          demand_nxt;
    logic          ready_r;
    logic          ready_nxt;
    logic          request_r;
    logic          request_nxt;
    logic          radio_r;
    logic          radio_nxt;
    logic          wake_req;
    logic          cnt_done;
    logic [CW-1:0] limit;

    assign wake_req = hreq | self_wake_in;

    always_comb begin
        case (state_r)
            npss_pkg::NPSS_STABILIZE: limit = CW'(STABILIZE_CYCLES - 1);
            npss_pkg::NPSS_SETTLE:    limit = CW'(SUPPLY_SET_CYCLES - 1);
            npss_pkg::NPSS_BOOT:      limit = CW'(BOOT_CYCLES - 1);
            npss_pkg::NPSS_LINGER:    limit = CW'(LINGER_CYCLES - 1);
            default:                  limit = npss_pkg::CNT_ZERO;
        endcase
    end

    assign cnt_done = (cnt_r >= limit);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + CW'(1);
        case (state_r)
            npss_pkg::NPSS_OFF: begin
                cnt_nxt = npss_pkg::CNT_ZERO;
                if (pwr) begin
                    state_nxt = npss_pkg::NPSS_STABILIZE;
                end
            end
            npss_pkg::NPSS_STABILIZE: begin
                if (cnt_done) begin
                    state_nxt = npss_pkg::NPSS_HELD;
                end
            end
            npss_pkg::NPSS_HELD: begin
                cnt_nxt = npss_pkg::CNT_ZERO;
                if (node_rstn) begin
                    state_nxt = npss_pkg::NPSS_SLEEP;
                end
            end
            npss_pkg::NPSS_SLEEP: begin
                cnt_nxt = npss_pkg::CNT_ZERO;
                if (wake_req) begin
                    state_nxt = npss_pkg::NPSS_SETTLE;
                end
            end
            npss_pkg::NPSS_SETTLE: begin
                // the main supply is trusted only after its settle time
                if (cnt_done) begin
                    state_nxt = npss_pkg::NPSS_BOOT;
                    cnt_nxt   = npss_pkg::CNT_ZERO;
                end
            end
            npss_pkg::NPSS_BOOT: begin
                if (cnt_done) begin
                    state_nxt = npss_pkg::NPSS_READY;
                end
            end
            npss_pkg::NPSS_READY: begin
                cnt_nxt = npss_pkg::CNT_ZERO;
                if (!wake_req && !attention_in) begin
                    state_nxt = npss_pkg::NPSS_LINGER;
                end
            end
            npss_pkg::NPSS_LINGER: begin
                if (wake_req || attention_in) begin
                    state_nxt = npss_pkg::NPSS_READY;
                    cnt_nxt   = npss_pkg::CNT_ZERO;
                end else if (cnt_done) begin
                    state_nxt = npss_pkg::NPSS_SLEEP;
                    cnt_nxt   = npss_pkg::CNT_ZERO;
                end
            end
            default: begin
                state_nxt = npss_pkg::NPSS_OFF;
                cnt_nxt   = npss_pkg::CNT_ZERO;
            end
        endcase
        // losing power enable overrides every other step; losing reset does so in every state but off and stabilize
        if (!pwr) begin
            state_nxt = npss_pkg::NPSS_OFF;
            cnt_nxt   = npss_pkg::CNT_ZERO;
        end else if (!node_rstn && state_r != npss_pkg::NPSS_OFF
                     && state_r != npss_pkg::NPSS_STABILIZE) begin
            state_nxt = npss_pkg::NPSS_HELD;
            cnt_nxt   = npss_pkg::CNT_ZERO;
        end

        demand_nxt = (state_nxt == npss_pkg::NPSS_SETTLE)
                   | (state_nxt == npss_pkg::NPSS_BOOT)
                   | (state_nxt == npss_pkg::NPSS_READY)
                   | (state_nxt == npss_pkg::NPSS_LINGER);
        ready_nxt   = (state_nxt == npss_pkg::NPSS_READY)
                    | (state_nxt == npss_pkg::NPSS_LINGER);
        request_nxt = ready_nxt & attention_in;
        // radio may only run once the supply has been declared clean
        radio_nxt   = ready_nxt & radio_on_in;
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            state_r   <= npss_pkg::NPSS_OFF;
            cnt_r     <= npss_pkg::CNT_ZERO;
            demand_r  <= 1'b0;
            ready_r   <= 1'b0;
            request_r <= 1'b0;
            radio_r   <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            demand_r  <= demand_nxt;
            ready_r   <= ready_nxt;
            request_r <= request_nxt;
            radio_r   <= radio_nxt;
        end
    end

    // spi slave, mode zero; ignored unless node ready
    logic                           sclk_d_r;
    logic                           sclk_d_nxt;
    logic [npss_pkg::BIT_W-1:0]     bit_r;
    logic [npss_pkg::BIT_W-1:0]     bit_nxt;
    logic [npss_pkg::BYTE_W-1:0]    rxs_r;
    logic [npss_pkg::BYTE_W-1:0]    rxs_nxt;
    logic [npss_pkg::BYTE_W-1:0]    txs_r;
    logic [npss_pkg::BYTE_W-1:0]    txs_nxt;
    logic [npss_pkg::BYTE_W-1:0]    rxd_r;
    logic [npss_pkg::BYTE_W-1:0]    rxd_nxt;
    logic                           rxv_r;
    logic                           rxv_nxt;
    logic                           spi_on;

    // a parked or sleeping link never shifts, whatever the pins show
    assign spi_on = ready_r & ~cs_n & (hreq | request_r);

    always_comb begin
        sclk_d_nxt = sclk;
        bit_nxt    = bit_r;
        rxs_nxt    = rxs_r;
        txs_nxt    = txs_r;
        rxd_nxt    = rxd_r;
        rxv_nxt    = 1'b0;
        if (!spi_on) begin
            // first bit must sit on miso before the first rising edge
            bit_nxt = '0;
            txs_nxt = tx_data_in;
        end else if (sclk && !sclk_d_r) begin
            rxs_nxt = {rxs_r[npss_pkg::BYTE_W-2:0], mosi};
            bit_nxt = bit_r + 3'h1;
            if (bit_r == npss_pkg::BIT_LAST) begin
                rxd_nxt = {rxs_r[npss_pkg::BYTE_W-2:0], mosi};
                rxv_nxt = 1'b1;
            end
        end else if (!sclk && sclk_d_r) begin
            // after a full byte the next one loads on the falling edge
            if (bit_r == '0) begin
                txs_nxt = tx_data_in;
            end else begin
                txs_nxt = {txs_r[npss_pkg::BYTE_W-2:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            sclk_d_r <= 1'b0;
            bit_r    <= '0;
            rxs_r    <= npss_pkg::BYTE_ZERO;
            txs_r    <= npss_pkg::BYTE_ZERO;
            rxd_r    <= npss_pkg::BYTE_ZERO;
            rxv_r    <= 1'b0;
        end else begin
            sclk_d_r <= sclk_d_nxt;
            bit_r    <= bit_nxt;
            rxs_r    <= rxs_nxt;
            txs_r    <= txs_nxt;
            rxd_r    <= rxd_nxt;
            rxv_r    <= rxv_nxt;
        end
    end

    assign supply_demand_out = demand_r;
    assign radio_active_out  = radio_r;
    assign node_ready_out    = ready_r;
    assign node_request_out  = request_r;
    assign miso_out          = spi_on & txs_r[npss_pkg::BYTE_W-1];
    assign miso_oe_out       = spi_on;
    assign rx_data_out       = rxd_r;
    assign rx_valid_out      = rxv_r;

endmodule

`default_nettype wire

//--- common/npss_pkg.sv
package npss_pkg;

    // system clock rate
    localparam int unsigned CLK_MHZ = 25;

    // minimum interval in microseconds to whole clock cycles, at least one
    function automatic int unsigned us_to_cycles(input int unsigned us);
        int unsigned c;
        c = us * CLK_MHZ;
        if (c < 1) begin
            c = 1;
        end
        return c;
    endfunction

    // settling of the 32 kHz clock and the internal reset after power enable
    localparam int unsigned STABILIZE_US  = 3000000;
    // main supply must be stable this long after supply demand rises
    localparam int unsigned SUPPLY_SET_US = 2000;
    // boot and initialisation before node ready
    localparam int unsigned BOOT_US       = 80000;
    // hold-off before falling back asleep, prevents rapid re-waking
    localparam int unsigned LINGER_US     = 1000;

    localparam int unsigned STABILIZE_CYC  = us_to_cycles(STABILIZE_US);
    localparam int unsigned SUPPLY_SET_CYC = us_to_cycles(SUPPLY_SET_US);
    localparam int unsigned BOOT_CYC       = us_to_cycles(BOOT_US);
    localparam int unsigned LINGER_CYC     = us_to_cycles(LINGER_US);

    localparam int unsigned CNT_W   = 32;
    localparam int unsigned BYTE_W  = 8;
    localparam int unsigned BIT_W   = 3;
    localparam int unsigned SYNC_N  = 6;

    // positions in the pin synchroniser vector
    localparam int unsigned PIN_PWR  = 0;
    localparam int unsigned PIN_RSTN = 1;
    localparam int unsigned PIN_HREQ = 2;
    localparam int unsigned PIN_SCLK = 3;
    localparam int unsigned PIN_CSN  = 4;
    localparam int unsigned PIN_MOSI = 5;

    // reset values of the filtered pins: chip select idles high
    localparam logic [SYNC_N-1:0] PIN_RESET = 6'h10;

    localparam logic [CNT_W-1:0]  CNT_ZERO  = 32'h0000_0000;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [BIT_W-1:0]  BIT_LAST  = 3'h7;

    typedef enum logic [2:0] {
        NPSS_OFF,
        NPSS_STABILIZE,
        NPSS_HELD,
        NPSS_SLEEP,
        NPSS_SETTLE,
        NPSS_BOOT,
        NPSS_READY,
        NPSS_LINGER
    } npss_state_t;

endpackage

//--- tb/npss_props.sv
`timescale 1ns/1ps
`default_nettype none

module npss_props (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic power_enable_in,
    input wire logic node_resetn_in,
    input wire logic host_request_in,
    input wire logic supply_demand_out,
    input wire logic radio_active_out,
    input wire logic node_ready_out,
    input wire logic node_request_out,
    input wire logic miso_oe_out,
    input wire logic rx_valid_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    // pins pass a four-flop filter, so causes must hold past that latency
    sequence awake_held;
        (host_request_in && power_enable_in && node_resetn_in)[*6];
    endsequence
    sequence power_gone;
        (!power_enable_in)[*7];
    endsequence

    a_request_needs_ready: assert property (
        node_request_out |-> node_ready_out)
        else $error("node request raised without node ready");
    a_ready_needs_supply: assert property (
        node_ready_out |-> supply_demand_out)
        else $error("node ready while supply demand low");
    a_sleep_no_radio: assert property (
        !supply_demand_out |-> !radio_active_out && !node_ready_out)
        else $error("activity while asleep");
    a_off_clears_all: assert property (
        power_gone |-> !supply_demand_out && !node_request_out)
        else $error("outputs alive with power enable low");
    a_boot_delay_seen: assert property (
        $rose(supply_demand_out) |-> (!node_ready_out)[*8])
        else $error("node ready too soon after wake");
    a_awake_kept: assert property (
        awake_held ##0 node_ready_out |=> node_ready_out)
        else $error("node dropped ready under host request");
    // chip select parks low while both requests are low, so miso must not
    // follow it then; the host request is seen four clocks late
    a_miso_when_ready: assert property (
        miso_oe_out |-> node_ready_out
                        && ($past(host_request_in, 4) || node_request_out))
        else $error("miso driven while not ready or link parked");
    a_rx_single_pulse: assert property (
        rx_valid_out |=> !rx_valid_out)
        else $error("byte strobe longer than one cycle");
endmodule

bind npss_node_sequencer npss_props chk (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .power_enable_in(power_enable_in), .node_resetn_in(node_resetn_in),
    .host_request_in(host_request_in), .supply_demand_out(supply_demand_out),
    .radio_active_out(radio_active_out), .node_ready_out(node_ready_out),
    .node_request_out(node_request_out), .miso_oe_out(miso_oe_out),
    .rx_valid_out(rx_valid_out)
);

`default_nettype wire

//--- tb/npss_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module npss_host_model (
    input  wire logic clk_in,
    input  wire logic miso_in,
    output logic      power_enable_out,
    output logic      node_resetn_out,
    output logic      host_request_out,
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      mosi_out
);
    // all low from time zero: nothing may back-power a sleeping node
    initial begin
        power_enable_out = 1'b0;
        node_resetn_out  = 1'b0;
        host_request_out = 1'b0;
        sclk_out         = 1'b0;
        cs_n_out         = 1'b0;
        mosi_out         = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic set_power(input logic lvl);
        power_enable_out = lvl;
    endtask

    task automatic power_up(input int settle);
        tick(10);
        power_enable_out = 1'b1;
        tick(settle);
        node_resetn_out = 1'b1;
        tick(10);
        host_request_out = 1'b1;
        tick(8);
        cs_n_out = 1'b1;
    endtask

    task automatic let_sleep();
        cs_n_out = 1'b0;
        mosi_out = 1'b0;
        host_request_out = 1'b0;
    endtask

    // miso is taken late in the high phase: the node sees sclk 4 clocks late
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        cs_n_out = 1'b0;
        tick(8);
        for (int i = 7; i >= 0; i--) begin
            mosi_out = tx[i];
            tick(4);
            sclk_out = 1'b1;
            tick(4);
            rx[i] = miso_in;
            sclk_out = 1'b0;
        end
        tick(8);
        cs_n_out = 1'b1;
        tick(4);
    endtask
endmodule

`default_nettype wire

//--- tb/node_power_spi_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none

module node_power_spi_sequencer_bench;
    localparam int SS    = 10;
    localparam int BT    = 30;
    localparam int ST    = 20;
    localparam int LN    = 8;
    localparam int LIMIT = 6000;

    logic       clk_in;
    logic       resetn_in;
    logic       self_wake_in;
    logic       attention_in;
    logic       radio_on_in;
    logic [7:0] tx_data_in;
    logic [7:0] rx_data_out;
    logic [7:0] rx_got;
    logic [7:0] miso_byte;
    logic [7:0] mosi_byte;
    logic       supply_demand_out;
    logic       radio_active_out;
    logic       node_ready_out;
    logic       node_request_out;
    logic       miso_out;
    logic       miso_oe_out;
    logic       rx_valid_out;
    wire logic  pe, nrst, hreq, sclk, cs_n, mosi;
    int         miscompares = 0;
    int         checked = 0;
    int         cycles = 0;
    int         n;

    npss_node_sequencer #(
        .STABILIZE_CYCLES(ST), .SUPPLY_SET_CYCLES(SS),
        .BOOT_CYCLES(BT), .LINGER_CYCLES(LN)
    ) uut (
        .clk_in(clk_in), .resetn_in(resetn_in), .power_enable_in(pe),
        .node_resetn_in(nrst), .host_request_in(hreq), .sclk_in(sclk),
        .cs_n_in(cs_n), .mosi_in(mosi), .self_wake_in(self_wake_in),
        .attention_in(attention_in), .radio_on_in(radio_on_in),
        .tx_data_in(tx_data_in), .supply_demand_out(supply_demand_out),
        .radio_active_out(radio_active_out), .node_ready_out(node_ready_out),
        .node_request_out(node_request_out), .miso_out(miso_out),
        .miso_oe_out(miso_oe_out), .rx_data_out(rx_data_out),
        .rx_valid_out(rx_valid_out)
    );

    npss_host_model host (
        .clk_in(clk_in), .miso_in(miso_out), .power_enable_out(pe),
        .node_resetn_out(nrst), .host_request_out(hreq),
        .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi)
    );

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (rx_valid_out === 1'b1) begin
            rx_got <= rx_data_out;
        end
        if (cycles == LIMIT) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [7:0] bit8(input logic b);
        return {7'h00, b};
    endfunction

    task automatic step(input int k);
        repeat (k) @(posedge clk_in);
        #1;
    endtask

    // bounded wait on supply demand (sel 0) or node ready (sel 1)
    task automatic wait_rise(input int sel, output int k);
        k = 0;
        while ((sel == 0 ? supply_demand_out : node_ready_out) !== 1'b1
               && k < 400) begin
            step(1);
            k++;
        end
        check("wait bound", bit8(k < 400), 8'h01);
    endtask

    initial begin
        resetn_in = 1'b0;
        self_wake_in = 1'b0;
        attention_in = 1'b0;
        radio_on_in = 1'b0;
        tx_data_in = 8'h00;
        rx_got = 8'h00;
        void'($urandom(81622));
        step(12);
        resetn_in = 1'b1;
        step(1);
        check("demand after reset", bit8(supply_demand_out), 8'h00);
        host.power_up(ST + 8);
        wait_rise(0, n);
        check("ready at wake", bit8(node_ready_out), 8'h00);
        wait_rise(1, n);
        // power_up returns eight cycles after host request rises
        check("boot length", bit8(n + 8 >= SS + BT && n <= SS + BT), 8'h01);
        for (int i = 0; i < 6; i++) begin
            radio_on_in = 1'($urandom_range(1));
            attention_in = (i == 2);
            tx_data_in = 8'($urandom);
            mosi_byte = 8'($urandom);
            if (i == 5) begin
                tx_data_in = 8'hff;
                mosi_byte = 8'h00;
            end
            step(6);
            check("node request", bit8(node_request_out), bit8(i == 2));
            check("radio active", bit8(radio_active_out), bit8(radio_on_in));
            check("demand in xfer", bit8(supply_demand_out), 8'h01);
            host.xfer(mosi_byte, miso_byte);
            step(2);
            check("rx byte", rx_got, mosi_byte);
            check("miso byte", miso_byte, tx_data_in);
        end
        attention_in = 1'b0;
        step(2);
        host.let_sleep();
        step(6);
        check("ready in linger", bit8(node_ready_out), 8'h01);
        check("miso parked", bit8(miso_oe_out), 8'h00);
        step(LN + 8);
        check("demand asleep", bit8(supply_demand_out), 8'h00);
        check("ready asleep", bit8(node_ready_out), 8'h00);
        self_wake_in = 1'b1;
        wait_rise(1, n);
        check("self wake boot", bit8(n >= SS + BT), 8'h01);
        check("self wake demand", bit8(supply_demand_out), 8'h01);
        self_wake_in = 1'b0;
        host.set_power(1'b0);
        step(8);
        check("off demand", bit8(supply_demand_out), 8'h00);
        check("off ready", bit8(node_ready_out), 8'h00);
        end_of_test();
    end
endmodule

`default_nettype wire
